// File: shared/qbs_pkg.sv
// package for the four-word burst sram port block: widths, latencies, pin bundle, slot states
// assumes one user module on a fast sampling clock; pin clocks are much slower than it
package qbs_pkg;

  localparam int WORD_W = 18;
  localparam int ADDR_W = 4;
  localparam int BURST = 4;
  localparam int IDX_W = 2;
  localparam int MEM_WORDS = (1 << ADDR_W) * BURST;
  localparam int RD_SLOTS = 2;
  localparam int CNT_W = 3;

  // read latency counted in output half-cycles (rising edges of the output pair)
  localparam logic [2:0] LAT_HALF_BYPASS_HI = 3'h3;
  localparam logic [2:0] LAT_HALF_BYPASS_LO = 3'h2;
  localparam logic [2:0] LAST_BEAT = 3'h3;

  typedef enum logic {
    SLOT_READ = 1'b0,
    SLOT_WRITE = 1'b1
  } qbs_slot_t;

  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic single_domain;
    logic pll_bypass;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } qbs_pins_t;

  localparam qbs_pins_t PINS_RST = '{k: 1'b0, k_n: 1'b0, c: 1'b0, c_n: 1'b0,
    single_domain: 1'b0, pll_bypass: 1'b0, read_port_select_n: 1'b1,
    write_port_select_n: 1'b1, addr: '0, wdata: '0};
  localparam qbs_slot_t PHASE_RST = SLOT_READ;

endpackage : qbs_pkg

// File: verilog/qbs_sram_core.sv
// four-word burst sram with separate read and write ports on one shared address bus
// assumes all pins are asynchronous to mclk_i, and input/output clocks far slower than it
module qbs_sram_core (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  input wire logic single_domain_i,
  input wire logic pll_bypass_i,
  input wire logic read_port_select_n_i,
  input wire logic write_port_select_n_i,
  input wire logic [qbs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [qbs_pkg::WORD_W-1:0] wdata_i,
  output logic [qbs_pkg::WORD_W-1:0] rdata_o,
  output logic read_valid_o,
  output logic echo_timing_pair_o,
  output logic echo_timing_pair_n_o
);

  //////////////////////////////////////////////////////////////////////////////////////
  // pin sampling: three stages, clock edges counted once stages two and three agree

  qbs_pkg::qbs_pins_t pins_in;
  qbs_pkg::qbs_pins_t s1;
  qbs_pkg::qbs_pins_t s2;
  qbs_pkg::qbs_pins_t s3;
  logic [3:0] lvl;
  logic [3:0] next_lvl;
  logic [3:0] s2c;
  logic [3:0] s3c;
  logic [3:0] rise;

  assign pins_in = '{k: k_i, k_n: k_n_i, c: c_i, c_n: c_n_i,
    single_domain: single_domain_i, pll_bypass: pll_bypass_i,
    read_port_select_n: read_port_select_n_i, write_port_select_n: write_port_select_n_i,
    addr: addr_i, wdata: wdata_i};

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s1 <= qbs_pkg::PINS_RST;
      s2 <= qbs_pkg::PINS_RST;
      s3 <= qbs_pkg::PINS_RST;
    end else begin
      s1 <= pins_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // data fields ride the same three stages as the clocks, so they stay aligned to edges
  assign s2c = {s2.k, s2.k_n, s2.c, s2.c_n};
  assign s3c = {s3.k, s3.k_n, s3.c, s3.c_n};
  assign next_lvl = (~(s2c ^ s3c) & s3c) | ((s2c ^ s3c) & lvl);
  assign rise = next_lvl & ~lvl;

  //////////////////////////////////////////////////////////////////////////////////////
  // core state

  logic k_rise;
  logic kn_rise;
  logic out_rise;
  logic out_n_rise;
  logic out_edge;
  logic [2:0] lat;

  qbs_pkg::qbs_slot_t phase;
  qbs_pkg::qbs_slot_t next_phase;
  logic [qbs_pkg::WORD_W-1:0] mem [qbs_pkg::MEM_WORDS];
  logic [qbs_pkg::WORD_W-1:0] next_mem [qbs_pkg::MEM_WORDS];
  logic wpend;
  logic next_wpend;
  logic [qbs_pkg::ADDR_W-1:0] wpaddr;
  logic [qbs_pkg::ADDR_W-1:0] next_wpaddr;
  logic wact;
  logic next_wact;
  logic [qbs_pkg::ADDR_W-1:0] waddr;
  logic [qbs_pkg::ADDR_W-1:0] next_waddr;
  logic [qbs_pkg::CNT_W-1:0] wcnt;
  logic [qbs_pkg::CNT_W-1:0] next_wcnt;
  logic [qbs_pkg::WORD_W-1:0] wbuf [qbs_pkg::BURST];
  logic [qbs_pkg::WORD_W-1:0] next_wbuf [qbs_pkg::BURST];
  logic ract [qbs_pkg::RD_SLOTS];
  logic next_ract [qbs_pkg::RD_SLOTS];
  logic [qbs_pkg::ADDR_W-1:0] raddr [qbs_pkg::RD_SLOTS];
  logic [qbs_pkg::ADDR_W-1:0] next_raddr [qbs_pkg::RD_SLOTS];
  logic [qbs_pkg::CNT_W-1:0] rcnt [qbs_pkg::RD_SLOTS];
  logic [qbs_pkg::CNT_W-1:0] next_rcnt [qbs_pkg::RD_SLOTS];
  logic rptr;
  logic next_rptr;
  logic [qbs_pkg::WORD_W-1:0] rdata;
  logic [qbs_pkg::WORD_W-1:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic echo;
  logic next_echo;

  assign k_rise = rise[3];
  assign kn_rise = rise[2];
  // single clock domain: the input pair also times the outputs
  assign out_rise = s3.single_domain ? rise[3] : rise[1];
  assign out_n_rise = s3.single_domain ? rise[2] : rise[0];
  assign out_edge = out_rise | out_n_rise;
  assign lat = s3.pll_bypass ? qbs_pkg::LAT_HALF_BYPASS_HI : qbs_pkg::LAT_HALF_BYPASS_LO;

  always_comb begin
    logic [qbs_pkg::CNT_W-1:0] c;
    logic [qbs_pkg::IDX_W-1:0] idx;
    logic hit;
    c = '0;
    idx = '0;
    hit = 1'b0;
    next_phase = phase;
    next_mem = mem;
    next_wpend = wpend;
    next_wpaddr = wpaddr;
    next_wact = wact;
    next_waddr = waddr;
    next_wcnt = wcnt;
    next_wbuf = wbuf;
    next_ract = ract;
    next_raddr = raddr;
    next_rcnt = rcnt;
    next_rptr = rptr;
    next_rdata = rdata;
    next_rvalid = rvalid;
    next_echo = echo;

    // write data beats: one word per k or k_n rise
    if ((k_rise || kn_rise) && wact) begin
      next_wbuf[wcnt[qbs_pkg::IDX_W-1:0]] = s3.wdata;
      next_wcnt = wcnt + 3'h1;
      if (wcnt == qbs_pkg::LAST_BEAT) begin
        // self-timed commit of the whole burst, no strobe from outside
        for (int i = 0; i < qbs_pkg::BURST; i++) begin
          next_mem[{waddr, i[qbs_pkg::IDX_W-1:0]}] = (i == qbs_pkg::BURST - 1) ? s3.wdata
                                                                             : wbuf[i];
        end
        next_wact = 1'b0;
        next_wcnt = '0;
      end
    end else if (k_rise && wpend && !wact) begin
      next_wact = 1'b1;
      next_waddr = wpaddr;
      next_wbuf[0] = s3.wdata;
      next_wcnt = 3'h1;
      next_wpend = 1'b0;
    end

    // read slots advance on each output edge; a slot lives for lat+3 edges
    for (int s = 0; s < qbs_pkg::RD_SLOTS; s++) begin
      if (ract[s] && out_edge) begin
        c = rcnt[s] + 3'h1;
        next_rcnt[s] = c;
        if (c >= lat && c <= lat + qbs_pkg::LAST_BEAT) begin
          idx = 2'(c - lat);
          hit = 1'b1;
          // forward beats of a burst still waiting for its array write
          if (wact && waddr == raddr[s] && {1'b0, idx} < wcnt) begin
            next_rdata = wbuf[idx];
          end else begin
            next_rdata = mem[{raddr[s], idx}];
          end
          if (c == lat + qbs_pkg::LAST_BEAT) begin
            next_ract[s] = 1'b0;
          end
        end
      end
    end
    if (out_edge) begin
      next_rvalid = hit;
    end

    // shared address: read slot then write slot on alternate k rises
    if (k_rise) begin
      unique case (phase)
        qbs_pkg::SLOT_READ: begin
          next_phase = qbs_pkg::SLOT_WRITE;
          if (!s3.read_port_select_n) begin
            next_ract[rptr] = 1'b1;
            next_raddr[rptr] = s3.addr;
            next_rcnt[rptr] = '0;
            next_rptr = ~rptr;
          end
        end
        qbs_pkg::SLOT_WRITE: begin
          next_phase = qbs_pkg::SLOT_READ;
          if (!s3.write_port_select_n) begin
            next_wpend = 1'b1;
            next_wpaddr = s3.addr;
          end
        end
      endcase
    end

    // echo follows the output pair so data is edge aligned to it
    if (out_rise) begin
      next_echo = 1'b1;
    end else if (out_n_rise) begin
      next_echo = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // registers; array contents are left as found at reset, like a real sram

  always_ff @(posedge mclk_i) begin
    mem <= next_mem;
    wbuf <= next_wbuf;
    raddr <= next_raddr;
    if (!reset_n_i) begin
      lvl <= '0;
      phase <= qbs_pkg::PHASE_RST;
      wpend <= 1'b0;
      wpaddr <= '0;
      wact <= 1'b0;
      waddr <= '0;
      wcnt <= '0;
      ract <= '{default: 1'b0};
      rcnt <= '{default: '0};
      rptr <= 1'b0;
      rdata <= '0;
      rvalid <= 1'b0;
      echo <= 1'b0;
    end else begin
      lvl <= next_lvl;
      phase <= next_phase;
      wpend <= next_wpend;
      wpaddr <= next_wpaddr;
      wact <= next_wact;
      waddr <= next_waddr;
      wcnt <= next_wcnt;
      ract <= next_ract;
      rcnt <= next_rcnt;
      rptr <= next_rptr;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      echo <= next_echo;
    end
  end

  assign rdata_o = rdata;
  assign read_valid_o = rvalid;
  assign echo_timing_pair_o = echo;
  assign echo_timing_pair_n_o = ~echo;

endmodule : qbs_sram_core

// File: verification/qbs_ctrl_model.sv
// controller model: timing pairs, shared address, selects, write beats
// assumes the bench calls xfer back to back; pins stand still between calls
module qbs_ctrl_model (
  input wire logic c_stop_i,
  output qbs_pkg::qbs_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [71:0] pend = 72'h0;
  initial pins_o = qbs_pkg::PINS_RST;
  ////////////////////////////////////////////////////////////////////////////////
  // unselected halves carry junk so a slot mix-up shows
  task automatic xfer(input logic rn, input logic [3:0] ra, input logic wn,
      input logic [3:0] wa, input logic [71:0] wd);
    for (int h = 0; h < 4; h++) begin
      #12;
      pins_o.addr <= (h == 0) ? ra : (h == 2) ? wa : ~pins_o.addr;
      pins_o.read_port_select_n <= (h == 0) ? rn : !rn;
      pins_o.write_port_select_n <= (h == 2) ? wn : !wn;
      pins_o.wdata <= pend[h*18 +: 18];
      #12;
      {pins_o.k, pins_o.k_n} <= {!h[0], h[0]};
      // output pair held still in single-domain runs, so only the k pair can time reads
      {pins_o.c, pins_o.c_n} <= c_stop_i ? 2'h0 : {!h[0], h[0]};
    end
    pend = wn ? ~pend : wd;
  endtask : xfer
endmodule : qbs_ctrl_model

// File: verification/qbs_sram_core_properties.sv
// checker for the burst sram core, bound to its ports
// assumes c pair in phase with k pair and mclk far faster than both
module qbs_sram_core_properties (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  input wire logic single_domain_i,
  input wire logic pll_bypass_i,
  input wire logic read_port_select_n_i,
  input wire logic write_port_select_n_i,
  input wire logic [qbs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [qbs_pkg::WORD_W-1:0] wdata_i,
  input wire logic [qbs_pkg::WORD_W-1:0] rdata_o,
  input wire logic read_valid_o,
  input wire logic echo_timing_pair_o,
  input wire logic echo_timing_pair_n_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic k_q, next_k_q, e_q, next_e_q;
  logic [3:0] k_age, next_k_age, beats, next_beats;
  ////////////////////////////////////////////////////////////////////////////////
  // k age saturates so idle gaps cannot wrap into the latency window
  always_comb begin
    next_k_q = k_i;
    next_e_q = echo_timing_pair_o;
    next_k_age = (k_i && !k_q) ? 4'h0 : k_age + {3'h0, k_age != 4'hf};
    next_beats = read_valid_o ? beats + {3'h0, echo_timing_pair_o != e_q} : 4'h0;
  end
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      {k_q, e_q, k_age, beats} <= {2'h0, 4'hf, 4'h0};
    end else begin
      {k_q, e_q, k_age, beats} <= {next_k_q, next_e_q, next_k_age, next_beats};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  reset_values_a: assert property (disable iff (1'b0) !reset_n_i |=> rdata_o == '0
    && !read_valid_o && !echo_timing_pair_o && echo_timing_pair_n_o) else $error("reset out");
  echo_pair_a: assert property (echo_timing_pair_n_o == !echo_timing_pair_o)
    else $error("echo pair not inverse");
  rdata_edge_a: assert property ($changed(rdata_o) |-> $changed(echo_timing_pair_o))
    else $error("rdata moved off output edge");
  echo_rise_a: assert property ($rose(echo_timing_pair_o) && !single_domain_i |->
    $past(c_i, 4)) else $error("echo rose without c");
  burst_whole_a: assert property ($fell(read_valid_o) |-> beats[1:0] == 2'h0)
    else $error("burst not four words");
  lat_phase_a: assert property ($rose(read_valid_o) |->
    echo_timing_pair_o == !pll_bypass_i) else $error("first word on wrong half");
  lat_hi_a: assert property ($rose(read_valid_o) && pll_bypass_i |->
    k_age inside {[4'h7:4'hc]}) else $error("long latency wrong");
  lat_lo_a: assert property ($rose(read_valid_o) && !pll_bypass_i |->
    k_age inside {[4'h2:4'h6]}) else $error("short latency wrong");
  cover property ($rose(read_valid_o) && pll_bypass_i);
  cover property ($rose(read_valid_o) && !pll_bypass_i);
  cover property (beats == 4'h8);
  cover property ($rose(read_valid_o) && single_domain_i);
endmodule : qbs_sram_core_properties
bind qbs_sram_core qbs_sram_core_properties qbs_sram_core_properties_inst (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .k_i(k_i), .k_n_i(k_n_i), .c_i(c_i), .c_n_i(c_n_i),
  .single_domain_i(single_domain_i), .pll_bypass_i(pll_bypass_i), .addr_i(addr_i),
  .read_port_select_n_i(read_port_select_n_i), .write_port_select_n_i(write_port_select_n_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .read_valid_o(read_valid_o),
  .echo_timing_pair_o(echo_timing_pair_o), .echo_timing_pair_n_o(echo_timing_pair_n_o));

// File: verification/qbs_sram_core_tb.sv
// self-checking bench: controller model, reference memory, word-by-word compare
// assumes x18 words and 16 burst locations as the package sets
module qbs_sram_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  qbs_pkg::qbs_pins_t pins;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic bypass = 1'b1;
  logic sdom = 1'b0;
  logic [17:0] rdata;
  logic valid, echo, echo_n, echo_q;
  logic [71:0] mem [16];
  logic [17:0] exp_q [$];
  logic [3:0] r = 4'h0;
  int fail_count, checks, cyc;
  always #2.5 mclk_i = ~mclk_i;
  qbs_ctrl_model qbs_ctrl_model_inst (.c_stop_i(sdom), .pins_o(pins));
  qbs_sram_core qbs_sram_core_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .k_i(pins.k),
    .k_n_i(pins.k_n), .c_i(pins.c), .c_n_i(pins.c_n), .single_domain_i(sdom),
    .pll_bypass_i(bypass), .read_port_select_n_i(pins.read_port_select_n),
    .write_port_select_n_i(pins.write_port_select_n), .addr_i(pins.addr),
    .wdata_i(pins.wdata), .rdata_o(rdata), .read_valid_o(valid),
    .echo_timing_pair_o(echo), .echo_timing_pair_n_o(echo_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // a write counts once its address is taken: later reads must see it even mid-burst
  task automatic op(input logic rn, input logic [3:0] ra, input logic wn, input logic [3:0] wa);
    logic [71:0] wd;
    wd = 72'({$urandom, $urandom, $urandom});
    if (!rn) for (int i = 0; i < 4; i++) exp_q.push_back(mem[ra][i*18 +: 18]);
    qbs_ctrl_model_inst.xfer(rn, ra, wn, wa, wd);
    if (!wn) mem[wa] = wd;
  endtask : op
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    echo_q <= echo;
    cyc++;
    if (reset_n_i) chk("echo_n", {17'h0, ~echo}, {17'h0, echo_n});
    if (reset_n_i && valid === 1'b1 && echo !== echo_q) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("[ERR] rdata expected none seen %h", rdata);
      end else chk("rdata", exp_q.pop_front(), rdata);
    end
    if (cyc == 4000) begin
      fail_count++;
      $display("[ERR] cycles expected below 4000 seen 4000");
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h87e5));
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    for (int i = 0; i < 16; i++) op(1'b1, 4'h0, 1'b0, 4'(i));
    for (int b = 0; b < 3; b++) begin
      repeat (3) op(1'b1, 4'h0, 1'b1, 4'h0);
      @(posedge mclk_i) {sdom, bypass} <= {b[1], b != 0};
      for (int n = 0; n < 24; n++) begin
        // a step of one lands the read on the burst still being written
        r = r + 4'h1 + 4'($urandom % 7);
        op($urandom % 4 == 0, r, $urandom % 4 == 0, r + 4'h1);
      end
    end
    repeat (3) op(1'b1, 4'h0, 1'b1, 4'h0);
    repeat (20) @(posedge mclk_i);
    chk("words left", 18'h0, 18'(exp_q.size()));
    stop_test();
  end
endmodule : qbs_sram_core_tb
